//--- ors_osc_partner.sv
/* Far-side model: three oscillators and the bus clock.
   Assumes ref_clk from the bench; a disabled oscillator holds its level. */
`timescale 1ns/10ps
module ors_osc_partner (
   input wire logic ref_clk,
   input wire logic internal_osc_enable,
   input wire logic rc_osc_enable,
   input wire logic crystal_osc_enable,
   output logic internal_osc_clock,
   output logic rc_osc_clock,
   output logic crystal_osc_clock,
   output logic bus_clock
);
   int n = 0;
   initial begin
      {internal_osc_clock, rc_osc_clock, crystal_osc_clock, bus_clock} = 4'h0;
   end
   // Distinct rates so a wrong source choice shows up
   always @(negedge ref_clk) begin
      n <= n + 1;
      if (internal_osc_enable) internal_osc_clock <= ~internal_osc_clock;
      if (rc_osc_enable && n % 3 == 0) rc_osc_clock <= ~rc_osc_clock;
      if (crystal_osc_enable && n % 5 == 0) crystal_osc_clock <= ~crystal_osc_clock;
   end
   always @(posedge ref_clk) bus_clock <= ~bus_clock;
endmodule : ors_osc_partner

//--- ors_osc_select.sv
/*
 * Reference clock selection for the oscillator unit: main reference,
 * timebase and watchdog clock paths, oscillator enables, output pin
 * and the two configuration registers.
 * Assumes oscillator levels arrive asynchronously and are sampled by a
 * much faster ref_clk; stop mode, the oscillator enable, the bus clock
 * level and the option byte come from logic on ref_clk.
 */
// Strobed register access was decided locally.
`timescale 1ns/10ps

// Functional notes
// - Option byte field picks main reference source
// - Main select field lives at FFCF
// - Output pin: inverted crystal, bus clock for internal/RC, low for unused code
// - RC code drives main; internal stays available
// - Internal code drives main reference
// - Config two field picks timebase source
// - Config two sits at 001D
// - RC/crystal reach timebase only if main
// - RC and crystal never enabled together
// - Internal oscillator runs from reset onward
// - Internal stops in stop only if asked
// - Watchdog always clocked by internal oscillator
// - Main reference feeds generator and subsystems
// - System enable gates all three oscillators
// - Stop halts RC/crystal unless keep bit
module ors_osc_select (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [ors_pkg::ORS_ADDR_W-1:0] reg_addr,
   input wire logic [ors_pkg::ORS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ors_pkg::ORS_DATA_W-1:0] reg_rdata,
   input wire logic [ors_pkg::ORS_DATA_W-1:0] option_byte_in,
   input wire logic osc_enable_from_sysint,
   input wire logic stop_mode,
   input wire logic bus_clock,
   input wire logic internal_osc_clock,
   input wire logic rc_osc_clock,
   input wire logic crystal_osc_clock,
   output logic main_ref_clock,
   output logic pll_ref_clock,
   output logic timebase_clock,
   output logic watchdog_clock,
   output logic osc_output_pin,
   output logic internal_osc_enable,
   output logic rc_osc_enable,
   output logic crystal_osc_enable
);
   import ors_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [ORS_NSRC-1:0] src_s1;
      logic [ORS_NSRC-1:0] src_s2;
      logic [ORS_DATA_W-1:0] cfg2;
      logic [ORS_DATA_W-1:0] opt;
      logic opt_loaded;
      logic [ORS_DATA_W-1:0] rdata;
      logic main_ref;
      logic pll_ref;
      logic tb;
      logic wd;
      logic osc_out;
      logic int_en;
      logic rc_en;
      logic xt_en;
   } ors_state_t;

   ors_state_t state_reg;
   ors_state_t state_next;

   logic [1:0] main_sel;
   logic [1:0] tb_sel;
   logic int_run;
   logic rc_run;
   logic xt_run;
   logic int_clk;
   logic rc_clk;
   logic xt_clk;
   logic main_clk;

   // ************************************************************
   // Selection and enables
   // ************************************************************
   always_comb begin
      // Until the option byte is captured the code reads as unused
      main_sel = state_reg.opt[ORS_OPT_SEL_HI:ORS_OPT_SEL_LO];
      tb_sel = state_reg.cfg2[ORS_CFG2_TB_HI:ORS_CFG2_TB_LO];

      // Internal source ignores main select; stops on system disable or in stop with disable bit
      int_run = osc_enable_from_sysint
         & ~(stop_mode & state_reg.cfg2[ORS_CFG2_STOP_INT_OFF]);
      // One select code per source, so RC and crystal never both run
      rc_run = osc_enable_from_sysint & (main_sel == ORS_MAIN_RC)
         & ~(stop_mode & ~state_reg.cfg2[ORS_CFG2_STOP_RC_KEEP]);
      xt_run = osc_enable_from_sysint & (main_sel == ORS_MAIN_XT)
         & ~(stop_mode & ~state_reg.cfg2[ORS_CFG2_STOP_XT_KEEP]);

      int_clk = state_reg.src_s2[ORS_SRC_INT] & state_reg.int_en;
      rc_clk = state_reg.src_s2[ORS_SRC_RC] & state_reg.rc_en;
      xt_clk = state_reg.src_s2[ORS_SRC_XT] & state_reg.xt_en;

      case (main_sel)
         ORS_MAIN_INT: begin
            main_clk = int_clk;
         end
         ORS_MAIN_RC: begin
            main_clk = rc_clk;
         end
         ORS_MAIN_XT: begin
            main_clk = xt_clk;
         end
         default: begin
            main_clk = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      state_next = state_reg;

      // Two-stage sampling of the asynchronous oscillator levels
      state_next.src_s1 = {crystal_osc_clock, rc_osc_clock, internal_osc_clock};
      state_next.src_s2 = state_reg.src_s1;

      // Option byte is non-volatile: caught once after reset release
      if (!state_reg.opt_loaded) begin
         state_next.opt = option_byte_in;
         state_next.opt_loaded = 1'b1;
      end

      if (reg_wr && (reg_addr == ORS_CFG2_ADDR)) begin
         state_next.cfg2 = reg_wdata & ORS_CFG2_WMASK;
      end

      // Read data stands only in the cycle after the strobe
      state_next.rdata = ORS_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            ORS_CFG2_ADDR: begin
               state_next.rdata = state_reg.cfg2;
            end
            ORS_OPT_ADDR: begin
               state_next.rdata = state_reg.opt;
            end
            ORS_STATUS_ADDR: begin
               state_next.rdata = {2'h0, stop_mode, osc_enable_from_sysint,
                  state_reg.src_s2 & {state_reg.xt_en, state_reg.rc_en, state_reg.int_en},
                  state_reg.opt_loaded};
            end
            default: begin
               state_next.rdata = ORS_ZERO;
            end
         endcase
      end

      state_next.int_en = int_run;
      state_next.rc_en = rc_run;
      state_next.xt_en = xt_run;

      // Generator and PLL share the buffered main reference
      state_next.main_ref = main_clk;
      state_next.pll_ref = main_clk;
      state_next.wd = int_clk;

      // Non-main external sources are not offered to the timebase
      case (tb_sel)
         ORS_TB_INT: begin
            state_next.tb = int_clk;
         end
         ORS_TB_RC: begin
            state_next.tb = (main_sel == ORS_MAIN_RC) & rc_clk;
         end
         ORS_TB_XT: begin
            state_next.tb = (main_sel == ORS_MAIN_XT) & xt_clk;
         end
         default: begin
            state_next.tb = 1'b0;
         end
      endcase

      case (main_sel)
         ORS_MAIN_XT: begin
            state_next.osc_out = ~state_reg.src_s2[ORS_SRC_XT];
         end
         ORS_MAIN_INT, ORS_MAIN_RC: begin
            state_next.osc_out = bus_clock;
         end
         default: begin
            state_next.osc_out = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.cfg2 <= ORS_CFG2_RESET;
         state_reg.opt <= ORS_OPT_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.rdata;
   assign main_ref_clock = state_reg.main_ref;
   assign pll_ref_clock = state_reg.pll_ref;
   assign timebase_clock = state_reg.tb;
   assign watchdog_clock = state_reg.wd;
   assign osc_output_pin = state_reg.osc_out;
   assign internal_osc_enable = state_reg.int_en;
   assign rc_osc_enable = state_reg.rc_en;
   assign crystal_osc_enable = state_reg.xt_en;

endmodule : ors_osc_select

//--- ors_osc_select_bench.sv
/* Self-checking bench for ors_osc_select.
   Assumes the partner model supplies oscillators and bus clock. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module ors_osc_select_bench;
   import ors_pkg::*;
   logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, osc_enable_from_sysint = 1, stop_mode = 0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00, option_byte_in = 8'h00, reg_rdata;
   logic main_ref_clock, pll_ref_clock, timebase_clock, watchdog_clock, osc_output_pin, bus_clock;
   logic internal_osc_clock, rc_osc_clock, crystal_osc_clock, b1;
   logic internal_osc_enable, rc_osc_enable, crystal_osc_enable;
   logic [2:0] h1, h2, h3;
   int fails = 0, samples_checked = 0;
   always #25 ref_clk = ~ref_clk;
   // Source history mirrors the two sync stages plus output register
   always @(posedge ref_clk) begin
      h1 <= {crystal_osc_clock, rc_osc_clock, internal_osc_clock};
      h2 <= h1;
      h3 <= h2;
      b1 <= bus_clock;
   end
   ors_osc_select ors_osc_select_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .option_byte_in, .osc_enable_from_sysint, .stop_mode, .bus_clock,
      .internal_osc_clock, .rc_osc_clock, .crystal_osc_clock, .main_ref_clock, .pll_ref_clock,
      .timebase_clock, .watchdog_clock, .osc_output_pin, .internal_osc_enable, .rc_osc_enable,
      .crystal_osc_enable);
   ors_osc_partner ors_osc_partner_inst (.ref_clk, .internal_osc_enable, .rc_osc_enable,
      .crystal_osc_enable, .internal_osc_clock, .rc_osc_clock, .crystal_osc_clock, .bus_clock);
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rdchk(input logic [15:0] a, input logic [7:0] e, input string n);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      `CHK(n, e, reg_rdata)
   endtask : rdchk
   task main_sel(input logic [1:0] code);
      logic em, et, ep;
      @(posedge ref_clk);
      rst <= 1'b1; option_byte_in <= {6'h00, code};
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(ORS_OPT_ADDR, {6'h00, code}, "option byte");
      for (int t = 0; t < 4; t++) begin
         wr(ORS_CFG2_ADDR, {6'h00, t[1:0]});
         repeat (6) @(negedge ref_clk);
         `CHK("rc enable", code == 2'd2, rc_osc_enable)
         `CHK("xtal enable", code == 2'd3, crystal_osc_enable)
         `CHK("int enable", 1'b1, internal_osc_enable)
         repeat (24) begin
            @(negedge ref_clk);
            em = (code == 2'd0) ? 1'b0 : h3[code - 2'd1];
            et = (t == 0) ? h3[0] : ((t == 1 && code == 2'd2) || (t == 2 && code == 2'd3))
               ? h3[t] : 1'b0;
            ep = (code == 2'd3) ? ~h3[2] : (code == 2'd0) ? 1'b0 : b1;
            `CHK("main ref", em, main_ref_clock)
            `CHK("pll ref", em, pll_ref_clock)
            `CHK("timebase", et, timebase_clock)
            `CHK("watchdog", h3[0], watchdog_clock)
            `CHK("output pin", ep, osc_output_pin)
         end
      end
      $display("main select %0d done", code);
   endtask : main_sel
   task stop_test;
      wr(ORS_CFG2_ADDR, 8'hff);
      rdchk(ORS_CFG2_ADDR, 8'h1f, "config two");
      wr(ORS_OPT_ADDR, 8'h01);
      rdchk(ORS_OPT_ADDR, 8'h03, "option read only");
      rdchk(16'h0010, 8'h00, "unmapped");
      wr(ORS_CFG2_ADDR, 8'h00);
      stop_mode <= 1'b1;
      repeat (4) @(negedge ref_clk);
      `CHK("int in stop", 1'b1, internal_osc_enable)
      `CHK("xtal in stop", 1'b0, crystal_osc_enable)
      wr(ORS_CFG2_ADDR, 8'h0c);
      repeat (4) @(negedge ref_clk);
      `CHK("int stop off", 1'b0, internal_osc_enable)
      `CHK("xtal kept", 1'b1, crystal_osc_enable)
      @(posedge ref_clk);
      osc_enable_from_sysint <= 1'b0;
      repeat (4) @(negedge ref_clk);
      `CHK("xtal sys off", 1'b0, crystal_osc_enable)
      $display("stop test done");
   endtask : stop_test
   initial begin
      // Software side: internal source is tried but never trusted for PLL accuracy
      for (int c = 0; c < 4; c++) main_sel(c[1:0]);
      stop_test();
      close_out();
   end
   initial begin
      repeat (6000) @(posedge ref_clk);
      fails++;
      close_out();
   end
endmodule : ors_osc_select_bench

//--- ors_osc_select_properties.sv
/* Port checker for ors_osc_select.
   Assumes a bind to every instance and a three-cycle source path. */
`timescale 1ns/10ps
module ors_osc_select_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [ors_pkg::ORS_DATA_W-1:0] reg_rdata,
   input wire logic osc_enable_from_sysint,
   input wire logic stop_mode,
   input wire logic bus_clock,
   input wire logic internal_osc_clock,
   input wire logic crystal_osc_clock,
   input wire logic main_ref_clock,
   input wire logic pll_ref_clock,
   input wire logic watchdog_clock,
   input wire logic osc_output_pin,
   input wire logic internal_osc_enable,
   input wire logic rc_osc_enable,
   input wire logic crystal_osc_enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   excl_rc_xt_a: assert property (!(rc_osc_enable && crystal_osc_enable))
      else $error("rc and crystal both on");
   pll_follows_a: assert property (pll_ref_clock == main_ref_clock)
      else $error("pll ref differs from main");
   wd_internal_a: assert property (watchdog_clock |-> $past(internal_osc_clock, 3))
      else $error("watchdog not from internal");
   main_enabled_a: assert property (main_ref_clock |-> $past(internal_osc_enable)
      || $past(rc_osc_enable) || $past(crystal_osc_enable)) else $error("main from idle source");
   int_runs_a: assert property (osc_enable_from_sysint && !stop_mode |=> internal_osc_enable)
      else $error("internal stopped");
   sys_off_a: assert property (!osc_enable_from_sysint |=> !internal_osc_enable
      && !rc_osc_enable && !crystal_osc_enable) else $error("enable without system");
   pin_bus_a: assert property (rc_osc_enable |-> osc_output_pin == $past(bus_clock))
      else $error("pin not bus clock");
   pin_xtal_a: assert property (crystal_osc_enable |-> osc_output_pin != $past(crystal_osc_clock, 3))
      else $error("pin not inverted crystal");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside slot");
endmodule : ors_osc_select_chk
bind ors_osc_select ors_osc_select_chk ors_osc_select_chk_inst (.ref_clk, .rst, .reg_rd,
   .reg_rdata, .osc_enable_from_sysint, .stop_mode, .bus_clock, .internal_osc_clock,
   .crystal_osc_clock, .main_ref_clock, .pll_ref_clock, .watchdog_clock, .osc_output_pin,
   .internal_osc_enable, .rc_osc_enable, .crystal_osc_enable);

//--- ors_pkg.sv
/*
 * Constants for the oscillator reference select block: register
 * addresses, field positions, reset values and source codes.
 * Assumes an 8-bit register port with 16-bit byte addresses.
 */
package ors_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int ORS_ADDR_W = 16;
   localparam int ORS_DATA_W = 8;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [ORS_ADDR_W-1:0] ORS_CFG2_ADDR = 16'hffff & 16'h001d;
   localparam logic [ORS_ADDR_W-1:0] ORS_OPT_ADDR = 16'hffcf;
   localparam logic [ORS_ADDR_W-1:0] ORS_STATUS_ADDR = 16'h001e;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int ORS_OPT_SEL_LO = 0;
   localparam int ORS_OPT_SEL_HI = 1;
   localparam int ORS_CFG2_TB_LO = 0;
   localparam int ORS_CFG2_TB_HI = 1;
   localparam int ORS_CFG2_STOP_INT_OFF = 2;
   localparam int ORS_CFG2_STOP_XT_KEEP = 3;
   localparam int ORS_CFG2_STOP_RC_KEEP = 4;
   localparam logic [ORS_DATA_W-1:0] ORS_CFG2_WMASK = 8'h1f;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [ORS_DATA_W-1:0] ORS_CFG2_RESET = 8'h00;
   localparam logic [ORS_DATA_W-1:0] ORS_OPT_RESET = 8'h00;
   localparam logic [ORS_DATA_W-1:0] ORS_ZERO = 8'h00;

   // ************************************************************
   // Source codes and source indices
   // ************************************************************
   localparam logic [1:0] ORS_MAIN_UNUSED = 2'h0;
   localparam logic [1:0] ORS_MAIN_INT = 2'h1;
   localparam logic [1:0] ORS_MAIN_RC = 2'h2;
   localparam logic [1:0] ORS_MAIN_XT = 2'h3;
   localparam logic [1:0] ORS_TB_INT = 2'h0;
   localparam logic [1:0] ORS_TB_RC = 2'h1;
   localparam logic [1:0] ORS_TB_XT = 2'h2;
   localparam logic [1:0] ORS_TB_UNUSED = 2'h3;
   localparam int ORS_SRC_INT = 0;
   localparam int ORS_SRC_RC = 1;
   localparam int ORS_SRC_XT = 2;
   localparam int ORS_NSRC = 3;

endpackage : ors_pkg
